/* logic/audio_in_pkg.sv */
// Shared constants, register map and carrier types for the audio input block.
`default_nettype none
package audio_in_pkg;

  ////////////////////////////////////////////////////////////////////////////
  localparam int CLK_HZ = 100_000_000;
  localparam int CLK_MHZ = CLK_HZ / 1_000_000;
  // A master or bit clock pin that shows no rising edge for this long counts as absent.
  localparam int ABSENT_NS = 20_000;
  localparam int ABSENT_CYC = ABSENT_NS * CLK_MHZ / 1000;
  // A frame longer than this counts as a lost frame clock.
  localparam int FRAME_TO_NS = 250_000;
  localparam int FRAME_TO_CYC = FRAME_TO_NS * CLK_MHZ / 1000;
  localparam int LOCK_FRAMES = 4;
  localparam int RATE_TOL_SHIFT = 6;
  localparam int MCLK_TOL = 2;
  localparam int NUM_RATES = 9;
  localparam int RATE_HZ [NUM_RATES] = '{8000, 11025, 12000, 16000, 22050,
                                         24000, 32000, 44100, 48000};
  localparam int NUM_MRATIO = 6;
  localparam int MCLK_RATIO [NUM_MRATIO] = '{64, 128, 192, 256, 384, 512};
  localparam logic [6:0] BCLK_32 = 7'h20;
  localparam logic [6:0] BCLK_48 = 7'h30;
  localparam logic [6:0] BCLK_64 = 7'h40;
  localparam logic [3:0] RATE_NONE = 4'hF;

  ////////////////////////////////////////////////////////////////////////////
  // Printed register offsets are indices; the byte address is four times.
  localparam logic [7:0] STATUS_IDX = 8'h01;
  localparam logic [7:0] IRQ_STAT_IDX = 8'h02;
  localparam logic [7:0] IRQ_MASK_IDX = 8'h03;
  localparam logic [7:0] FORMAT_IDX = 8'h04;
  localparam logic [7:0] DETECT_IDX = 8'h05;
  localparam logic [7:0] VOLUME_IDX = 8'h0E;
  localparam int FMT_LSB = 0;
  localparam int WLEN_LSB = 4;
  localparam int VOL_LSB = 0;
  localparam int SOFT_BIT = 8;
  localparam logic [31:0] FORMAT_RST = 32'h0000_0020;
  localparam logic [31:0] VOLUME_RST = 32'h0000_00FF;
  localparam int IRQ_ERR = 0;
  localparam int IRQ_LOCK = 1;
  localparam int IRQ_W = 2;
  localparam int ST_LOCK = 0;
  localparam int ST_OSC = 1;
  localparam int ST_MUTE = 2;
  localparam int ST_RAMP = 3;

  ////////////////////////////////////////////////////////////////////////////
  typedef enum logic [1:0] {
    FMT_I2S = 2'b00,
    FMT_LEFT_JUSTIFIED = 2'b01,
    FMT_RIGHT_JUSTIFIED = 2'b10
  } fmt_t;

  typedef enum logic [1:0] {
    CS_LIMP = 2'b00,
    CS_RUN = 2'b01,
    CS_MUTE = 2'b10
  } clk_state_t;

  typedef struct packed {
    logic mclk;
    logic bclk;
    logic fsel;
    logic data;
  } pin_bus_t;

  typedef struct packed {
    logic [9:0] mclk_ratio;
    logic [6:0] bclk_ratio;
    logic [3:0] rate;
  } detect_t;

  typedef struct packed {
    logic signed [23:0] left;
    logic signed [23:0] right;
  } sample_pair_t;

endpackage
`default_nettype wire

/* logic/serial_audio_input_clock_detect.sv */
// Slave serial audio receiver with clock checking and rate detection.
`timescale 1ns/1ps
`default_nettype none
module serial_audio_input_clock_detect
  import audio_in_pkg::*;
#(
  parameter int ADDR_W = 8,
  parameter int FRAME_TIMEOUT = FRAME_TO_CYC,
  parameter int LOCK_COUNT = LOCK_FRAMES
)(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic master_clock_in,
  input wire logic bit_clock_in,
  input wire logic frame_select_in,
  input wire logic serial_audio_in,
  output sample_pair_t samples,
  output logic sample_valid,
  output logic use_internal_osc,
  output logic audio_mute,
  output logic [7:0] gain,
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [5:0] word_len(input logic [1:0] code);
    case (code)
      2'b00: word_len = 6'd16;
      2'b01: word_len = 6'd20;
      default: word_len = 6'd24;
    endcase
  endfunction

  function automatic logic [3:0] rate_class(input logic [15:0] per);
    int nom;
    int diff;
    rate_class = RATE_NONE;
    for (int i = 0; i < NUM_RATES; i++)
    begin
      nom = CLK_HZ / RATE_HZ[i];
      diff = int'(per) - nom;
      if (diff < 0)
        diff = -diff;
      if (diff <= (nom >> RATE_TOL_SHIFT))
        rate_class = 4'(i);
    end
  endfunction

  function automatic logic [9:0] mclk_class(input logic [10:0] cnt);
    int diff;
    mclk_class = '0;
    for (int i = 0; i < NUM_MRATIO; i++)
    begin
      diff = int'(cnt) - MCLK_RATIO[i];
      if (diff <= MCLK_TOL && diff >= -MCLK_TOL)
        mclk_class = 10'(MCLK_RATIO[i]);
    end
  endfunction

  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [7:0] idx);
    hit = (a[ADDR_W-1:2] == (ADDR_W-2)'(idx));
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Every pin is asynchronous to pclk: two flops, then a third for edges.
  pin_bus_t s1_q;
  pin_bus_t s2_q;
  pin_bus_t s3_q;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end
    else
    begin
      s1_q <= '{master_clock_in, bit_clock_in, frame_select_in,
                serial_audio_in};
      s2_q <= s1_q;
      s3_q <= s2_q;
    end

  logic bclk_rise;
  logic mclk_rise;
  assign bclk_rise = s2_q.bclk & ~s3_q.bclk;
  assign mclk_rise = s2_q.mclk & ~s3_q.mclk;

  ////////////////////////////////////////////////////////////////////////////
  // Registers.
  logic [31:0] format_q;
  logic [31:0] volume_q;
  logic [IRQ_W-1:0] irq_stat_q;
  logic [IRQ_W-1:0] irq_mask_q;
  logic [IRQ_W-1:0] irq_set;
  logic wr_en;
  fmt_t fmt;
  logic [5:0] wl;
  assign wr_en = psel & penable & pready & pwrite;
  assign fmt = fmt_t'(format_q[FMT_LSB +: 2]);
  assign wl = word_len(format_q[WLEN_LSB +: 2]);

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      format_q <= FORMAT_RST;
      volume_q <= VOLUME_RST;
      irq_mask_q <= '0;
    end
    else if (wr_en)
    begin
      if (hit(paddr, FORMAT_IDX))
        format_q <= pwdata;
      if (hit(paddr, VOLUME_IDX))
        volume_q <= pwdata;
      if (hit(paddr, IRQ_MASK_IDX))
        irq_mask_q <= pwdata[IRQ_W-1:0];
    end

  // A new event wins over a clear that lands in the same cycle.
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      irq_stat_q <= '0;
      irq <= 1'b0;
    end
    else
    begin
      if (wr_en && hit(paddr, IRQ_STAT_IDX))
        irq_stat_q <= (irq_stat_q & ~pwdata[IRQ_W-1:0]) | irq_set;
      else
        irq_stat_q <= irq_stat_q | irq_set;
      irq <= |((irq_stat_q | irq_set) & irq_mask_q);
    end

  ////////////////////////////////////////////////////////////////////////////
  // Frame measurement: bits, master clocks and cycles are counted between frame clock rises.
  logic fs_d1_q;
  logic [7:0] bit_cnt_q;
  logic [10:0] mclk_cnt_q;
  logic [15:0] per_cnt_q;
  logic [15:0] since_mclk_q;
  logic [15:0] since_bclk_q;
  logic frame_start;
  logic absent;
  logic bits_ok;
  detect_t det;
  logic frame_good;
  assign frame_start = bclk_rise & s2_q.fsel & ~fs_d1_q;
  assign bits_ok = (bit_cnt_q[6:0] == BCLK_32 || bit_cnt_q[6:0] == BCLK_48 ||
                    bit_cnt_q[6:0] == BCLK_64) && !bit_cnt_q[7];
  assign det = '{mclk_class(mclk_cnt_q), bit_cnt_q[6:0],
                 rate_class(per_cnt_q)};
  assign frame_good = bits_ok && det.mclk_ratio != '0 &&
                      det.rate != RATE_NONE;
  assign absent = since_mclk_q >= 16'(ABSENT_CYC) ||
                  since_bclk_q >= 16'(ABSENT_CYC) ||
                  per_cnt_q >= 16'(FRAME_TIMEOUT);

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      fs_d1_q <= 1'b0;
      bit_cnt_q <= '0;
      mclk_cnt_q <= '0;
      per_cnt_q <= '0;
    end
    else
    begin
      if (bclk_rise)
        fs_d1_q <= s2_q.fsel;
      if (frame_start)
      begin
        bit_cnt_q <= 8'd1;
        mclk_cnt_q <= {10'd0, mclk_rise};
        per_cnt_q <= 16'd1;
      end
      else
      begin
        if (bclk_rise && bit_cnt_q != '1)
          bit_cnt_q <= bit_cnt_q + 8'd1;
        if (mclk_rise && mclk_cnt_q != '1)
          mclk_cnt_q <= mclk_cnt_q + 11'd1;
        if (per_cnt_q != '1)
          per_cnt_q <= per_cnt_q + 16'd1;
      end
    end

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      since_mclk_q <= '0;
      since_bclk_q <= '0;
    end
    else
    begin
      since_mclk_q <= mclk_rise ? '0 :
                      since_mclk_q + 16'(since_mclk_q != '1);
      since_bclk_q <= bclk_rise ? '0 :
                      since_bclk_q + 16'(since_bclk_q != '1);
    end

  ////////////////////////////////////////////////////////////////////////////
  // Clock supervisor: mute first, then fall back to the oscillator.
  clk_state_t cs_q;
  detect_t locked_q;
  detect_t cand_q;
  logic [7:0] good_cnt_q;
  logic ramp_q;
  logic clk_err;
  logic relock;
  logic [7:0] vol;
  assign vol = volume_q[VOL_LSB +: 8];
  assign clk_err = (cs_q == CS_RUN) &&
                   (absent || (frame_start &&
                    (!frame_good || det != locked_q)));
  // A lost clock in the same cycle blocks the relock, so the flag and the
  // state machine never disagree about it.
  assign relock = (cs_q == CS_LIMP) && !absent && frame_start &&
                  frame_good && det == cand_q &&
                  good_cnt_q >= 8'(LOCK_COUNT - 1);
  assign irq_set = {relock, clk_err};

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      cs_q <= CS_LIMP;
      locked_q <= '0;
      cand_q <= '0;
      good_cnt_q <= '0;
    end
    else
      case (cs_q)
        CS_LIMP:
        begin
          if (absent)
            good_cnt_q <= '0;
          else if (relock)
          begin
            cs_q <= CS_RUN;
            locked_q <= det;
            good_cnt_q <= '0;
          end
          else if (frame_start)
          begin
            cand_q <= det;
            if (frame_good && det == cand_q)
              good_cnt_q <= good_cnt_q + 8'd1;
            else
              good_cnt_q <= '0;
          end
        end
        CS_RUN:
          if (clk_err)
            cs_q <= CS_MUTE;
        CS_MUTE:
          cs_q <= CS_LIMP;
        default:
          cs_q <= CS_LIMP;
      endcase

  // The oscillator takes over only after the mute has reached the output.
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      use_internal_osc <= 1'b1;
    else
      use_internal_osc <= (cs_q != CS_RUN) && !relock;

  // Soft unmute steps the gain once per frame, so it lasts vol frames.
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      gain <= '0;
      audio_mute <= 1'b1;
      ramp_q <= 1'b0;
    end
    else if (clk_err || cs_q != CS_RUN)
    begin
      gain <= '0;
      audio_mute <= !relock;
      ramp_q <= relock && volume_q[SOFT_BIT];
      if (relock && !volume_q[SOFT_BIT])
        gain <= vol;
    end
    else if (ramp_q)
    begin
      audio_mute <= 1'b0;
      if (gain >= vol)
      begin
        gain <= vol;
        ramp_q <= 1'b0;
      end
      else if (frame_start)
        gain <= gain + 8'd1;
    end
    else
    begin
      audio_mute <= 1'b0;
      gain <= vol;
    end

  ////////////////////////////////////////////////////////////////////////////
  // Deserialiser. I2S looks at the frame clock one bit late, which turns
  // its delayed MSB into the same slot shape as left-justified.
  logic eff_fs;
  logic eff_prev_q;
  logic boundary;
  logic left_level;
  logic [31:0] sh_q;
  logic [5:0] cap_cnt_q;
  logic slot_ok_q;
  logic have_left_q;
  // The left word waits here so that both halves reach the output together.
  logic signed [23:0] left_q;
  logic signed [23:0] word;
  assign eff_fs = (fmt == FMT_I2S) ? fs_d1_q : s2_q.fsel;
  assign boundary = eff_fs != eff_prev_q;
  assign left_level = (fmt != FMT_I2S);
  always_comb
    case (format_q[WLEN_LSB +: 2])
      2'b00: word = {sh_q[15:0], 8'h00};
      2'b01: word = {sh_q[19:0], 4'h0};
      default: word = sh_q[23:0];
    endcase

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      eff_prev_q <= 1'b0;
      sh_q <= '0;
      cap_cnt_q <= '0;
      slot_ok_q <= 1'b0;
      have_left_q <= 1'b0;
      left_q <= '0;
      samples <= '0;
      sample_valid <= 1'b0;
    end
    else
    begin
      sample_valid <= 1'b0;
      if (clk_err || cs_q != CS_RUN)
      begin
        slot_ok_q <= 1'b0;
        have_left_q <= 1'b0;
        if (bclk_rise)
          eff_prev_q <= eff_fs;
      end
      else if (bclk_rise)
      begin
        eff_prev_q <= eff_fs;
        if (boundary)
        begin
          if (slot_ok_q && eff_prev_q == left_level)
          begin
            left_q <= word;
            have_left_q <= 1'b1;
          end
          else if (slot_ok_q && have_left_q)
          begin
            samples.left <= left_q;
            samples.right <= word;
            sample_valid <= 1'b1;
            have_left_q <= 1'b0;
          end
          sh_q <= {31'd0, s2_q.data};
          cap_cnt_q <= 6'd1;
          slot_ok_q <= 1'b1;
        end
        else if (fmt == FMT_RIGHT_JUSTIFIED)
          sh_q <= {sh_q[30:0], s2_q.data};
        else if (cap_cnt_q < wl)
        begin
          sh_q <= {sh_q[30:0], s2_q.data};
          cap_cnt_q <= cap_cnt_q + 6'd1;
        end
      end
    end

  ////////////////////////////////////////////////////////////////////////////
  // APB slave: one setup cycle, then an access cycle with pready high.
  logic [31:0] rdata_d;
  logic mapped;
  always_comb
  begin
    rdata_d = '0;
    mapped = 1'b1;
    if (hit(paddr, STATUS_IDX))
    begin
      rdata_d[ST_LOCK] = (cs_q == CS_RUN);
      rdata_d[ST_OSC] = use_internal_osc;
      rdata_d[ST_MUTE] = audio_mute;
      rdata_d[ST_RAMP] = ramp_q;
    end
    else if (hit(paddr, IRQ_STAT_IDX))
      rdata_d[IRQ_W-1:0] = irq_stat_q;
    else if (hit(paddr, IRQ_MASK_IDX))
      rdata_d[IRQ_W-1:0] = irq_mask_q;
    else if (hit(paddr, FORMAT_IDX))
      rdata_d = format_q;
    else if (hit(paddr, DETECT_IDX))
      rdata_d[$bits(detect_t)-1:0] = (cs_q == CS_RUN) ? locked_q : det;
    else if (hit(paddr, VOLUME_IDX))
      rdata_d = volume_q;
    else
      mapped = 1'b0;
  end

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
    end
    else
    begin
      pready <= psel & ~penable & ~pready;
      pslverr <= psel & ~penable & ~pready & ~mapped;
      prdata <= (psel & ~penable & ~pwrite & mapped) ? rdata_d : '0;
    end

endmodule
`default_nettype wire

/* sim/audio_rx_chk.sv */
// Port-level assertions for the serial audio receiver.
`timescale 1ns/1ps
`default_nettype none
module audio_rx_chk
  import audio_in_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic bit_clock_in,
  input wire sample_pair_t samples,
  input wire logic sample_valid,
  input wire logic use_internal_osc,
  input wire logic audio_mute,
  input wire logic [7:0] gain
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  ////////////////////////////////////////////////////////////////////////////
  // Cycles since the raw bit clock pin last rose, saturating.
  logic bclk_q;
  logic [3:0] age_q;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      bclk_q <= 1'b0;
      age_q <= 4'hF;
    end
    else
    begin
      bclk_q <= bit_clock_in;
      if (bit_clock_in && !bclk_q)
        age_q <= 4'h0;
      else if (age_q != 4'hF)
        age_q <= age_q + 4'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  a_mute_before_limp: assert property
    ($rose(use_internal_osc) |-> $past(audio_mute)) else $error("limp unmuted");
  a_limp_follows: assert property
    ($rose(audio_mute) |=> use_internal_osc) else $error("no limp after mute");
  a_gain_muted: assert property
    (audio_mute |-> gain == 8'h00) else $error("gain while muted");
  a_unmute_next: assert property
    ($fell(use_internal_osc) |-> $fell(audio_mute)) else $error("no unmute");
  a_no_sample_limp: assert property
    (sample_valid |-> !use_internal_osc) else $error("sample in limp");
  a_valid_pulse: assert property
    (sample_valid |=> !sample_valid) else $error("valid too long");
  a_samples_hold: assert property
    ($changed(samples) |-> sample_valid) else $error("samples moved");
  a_bit_latency: assert property
    (sample_valid |-> age_q <= 4'h8) else $error("pair not at bit edge");
  a_apb_answer: assert property
    (psel && !penable |=> pready ##1 !pready) else $error("bad answer");
  a_err_ready: assert property
    (pslverr |-> pready) else $error("error without ready");
  c_lock: cover property ($fell(use_internal_osc));
  c_error: cover property ($rose(audio_mute));
  c_pair: cover property (sample_valid);
endmodule

bind serial_audio_input_clock_detect audio_rx_chk i_chk (
  .pclk(pclk),
  .presetn(presetn),
  .psel(psel),
  .penable(penable),
  .pready(pready),
  .pslverr(pslverr),
  .bit_clock_in(bit_clock_in),
  .samples(samples),
  .sample_valid(sample_valid),
  .use_internal_osc(use_internal_osc),
  .audio_mute(audio_mute),
  .gain(gain)
);
`default_nettype wire

/* sim/audio_src.sv */
// Behavioural audio processor driving the receiver's clock and data pins.
`timescale 1ns/1ps
`default_nettype none
module audio_src (
  output logic mclk,
  output logic bclk,
  output logic fsel,
  output logic data
);
  realtime next_t = 0.0;

  initial
  begin
    mclk = 1'b0;
    forever #40.625 mclk = ~mclk;
  end

  initial
  begin
    bclk = 1'b1;
    fsel = 1'b0;
    data = 1'b0;
  end

  // Bits lead each frame and the bit clock then stands still, so register
  // traffic during the gap never stretches the frame period.
  task automatic send_frame(input int fmt, input int bpf, input int n,
    input logic [23:0] l, input logic [23:0] r);
    int s;
    int k;
    if (next_t > $realtime)
      #(next_t - $realtime);
    next_t = $realtime + 20800.0;
    s = bpf / 2;
    for (int i = 0; i < bpf; i++)
    begin
      k = i % s;
      if (fmt == 2)
        k = k - (s - n);
      else if (fmt == 0)
        k = k - 1;
      bclk = 1'b0;
      fsel = (i < s) ^ (fmt == 0);
      // Unused positions toggle, so a stray capture cannot match.
      data = (k < 0 || k >= n) ? i[0] : (i < s ? l[n-1-k] : r[n-1-k]);
      #62.5 bclk = 1'b1;
      #62.5;
    end
  endtask
endmodule
`default_nettype wire

/* sim/tb_serial_audio_input_clock_detect.sv */
// Self-checking bench for the serial audio receiver.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) check(48'(a), 48'(e))
module tb_serial_audio_input_clock_detect
  import audio_in_pkg::*;
;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, rd;
  logic pready, pslverr, err, sample_valid, use_internal_osc, audio_mute, irq;
  logic mclk, bclk, fsel, sdata;
  logic [7:0] gain;
  sample_pair_t samples;
  logic [47:0] exp_q[$];
  int n_errors = 0;
  int n_compared = 0;

  initial
  begin
    forever #5 pclk = ~pclk;
  end

  serial_audio_input_clock_detect #(
    .FRAME_TIMEOUT(5000),
    .LOCK_COUNT(2)
  ) i_dut (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .master_clock_in(mclk),
    .bit_clock_in(bclk),
    .frame_select_in(fsel),
    .serial_audio_in(sdata),
    .samples(samples),
    .sample_valid(sample_valid),
    .use_internal_osc(use_internal_osc),
    .audio_mute(audio_mute),
    .gain(gain),
    .irq(irq)
  );

  audio_src i_src (
    .mclk(mclk),
    .bclk(bclk),
    .fsel(fsel),
    .data(sdata)
  );

  ////////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish();
    if (n_errors == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic check(input logic [47:0] a, input logic [47:0] e);
    n_compared++;
    if (a !== e)
    begin
      n_errors++;
      $display("FAIL %0t got %0h exp %0h", $time, a, e);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] idx,
    input logic [31:0] wd);
    int t;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {idx[5:0], 2'b00};
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    t = 0;
    do
    begin
      @(posedge pclk);
      t++;
    end
    while (pready !== 1'b1 && t < 16);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1)
    begin
      n_errors++;
      tally_and_finish();
    end
  endtask

  // Reference model: words are left-aligned into 24 signed bits.
  task automatic frame(input int fmt, input int bpf, input int n,
    input bit chk);
    logic [23:0] l;
    logic [23:0] r;
    l = 24'($urandom) >> (24 - n);
    r = 24'h00_0001 << (n - 1);
    i_src.send_frame(fmt, bpf, n, l, r);
    if (chk)
      exp_q.push_back({24'(l << (24 - n)), 24'(r << (24 - n))});
  endtask

  task automatic lock(input int fmt, input int bpf, input int n);
    int t;
    t = 0;
    do
    begin
      frame(fmt, bpf, n, 1'b0);
      t++;
    end
    while (use_internal_osc !== 1'b0 && t < 8);
    if (use_internal_osc !== 1'b0)
    begin
      n_errors++;
      tally_and_finish();
    end
    frame(fmt, bpf, n, 1'b0);
  endtask

  task automatic cfg(input int fmt, input int bpf, input int wl);
    apb(1'b1, FORMAT_IDX, 32'(fmt + 16 * wl));
    frame(fmt, bpf, 16 + 4 * wl, 1'b1);
    frame(fmt, bpf, 16 + 4 * wl, 1'b0);
  endtask

  always @(posedge pclk)
  begin
    if (sample_valid === 1'b1 && exp_q.size() > 0)
      `CHK(samples, exp_q.pop_front());
  end

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    void'($urandom(32'hc139));
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, FORMAT_IDX, 32'h0000_0000);
    `CHK(rd, FORMAT_RST);
    apb(1'b0, VOLUME_IDX, 32'h0000_0000);
    `CHK(rd, VOLUME_RST);
    apb(1'b0, 8'h3F, 32'h0000_0000);
    `CHK({err, rd}, 33'h1_0000_0000);
    apb(1'b1, IRQ_MASK_IDX, 32'h0000_0003);
    lock(0, 64, 24);
    `CHK({use_internal_osc, audio_mute, gain, irq}, 11'h1FF);
    apb(1'b0, DETECT_IDX, 32'h0000_0000);
    `CHK(rd[10:0], 11'h408);
    apb(1'b0, IRQ_STAT_IDX, 32'h0000_0000);
    `CHK(rd, 32'h0000_0002);
    apb(1'b1, IRQ_STAT_IDX, 32'h0000_0003);
    apb(1'b1, IRQ_MASK_IDX, 32'h0000_0001);
    `CHK(irq, 1'b0);
    for (int w = 0; w < 3; w++)
      cfg(0, 64, w);
    // The framing change drops a frame edge, which must count as an error.
    apb(1'b1, FORMAT_IDX, 32'h0000_0021);
    frame(1, 48, 24, 1'b0);
    frame(1, 48, 24, 1'b0);
    `CHK({use_internal_osc, audio_mute, gain, irq}, 11'h601);
    apb(1'b1, IRQ_STAT_IDX, 32'h0000_0001);
    lock(1, 48, 24);
    `CHK(irq, 1'b0);
    for (int w = 0; w < 3; w++)
      cfg(1, 48, w);
    for (int w = 0; w < 3; w++)
      cfg(2, 48, w);
    apb(1'b1, VOLUME_IDX, 32'h0000_0140);
    frame(2, 40, 16, 1'b0);
    frame(2, 40, 16, 1'b0);
    `CHK(use_internal_osc, 1'b1);
    lock(2, 32, 16);
    `CHK(gain > 8'h00 && gain < 8'h04, 1'b1);
    cfg(2, 32, 0);
    `CHK(exp_q.size(), 0);
    tally_and_finish();
  end
endmodule
`default_nettype wire
